// ==== src/isf_pkg.sv ====
// constants shared by the status flag block
package isf_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFS_STATUS    = 8'h00;
   localparam logic [7:0]  OFS_MODE      = 8'h04;
   localparam logic [7:0]  OFS_RXDATA    = 8'h08;
   localparam logic [7:0]  OFS_IRQ_EN    = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_CLR   = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h14;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // ****************************************
   // bus_status field positions
   // ****************************************
   localparam int          ST_SLAVE_TX_DIRECTION       = 14;
   localparam int          ST_NACK_SENT_FLAG    = 13;
   localparam int          ST_BUSY       = 12;
   localparam int          ST_OVR        = 11;
   localparam int          ST_TXE        = 10;
   localparam int          ST_AAS        = 9;
   localparam int          ST_GC         = 8;
   localparam int          ST_TXR        = 4;
   localparam int          ST_RXR        = 3;
   localparam int          ST_ACR        = 2;
   localparam int          ST_NACK       = 1;
   localparam int          ST_ARB        = 0;
   localparam logic [15:0] ST_W1C_MASK   = 16'h700F;
   localparam logic [15:0] ST_RST        = 16'h0410;
   // ****************************************
   // mode_control_reg and interrupt layout
   // ****************************************
   localparam int          MODE_RUN      = 0;
   localparam int          MODE_LB       = 1;
   localparam logic [1:0]  MODE_RST      = 2'h0;
   localparam int          IRQ_N         = 4;
   localparam int          IRQ_RXB       = 0;
   localparam int          IRQ_OVR       = 1;
   localparam int          IRQ_START     = 2;
   localparam int          IRQ_STOP      = 3;
   // ****************************************
   // serial framing
   // ****************************************
   localparam int          BYTE_BITS     = 8;
   localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
   localparam logic [3:0]  ACK_BIT       = 4'h8;
endpackage

// ==== src/isf_sync.sv ====
// two flip-flop synchroniser for pins
module isf_sync
   import isf_pkg::*;
#(
   parameter int W = 2
)(
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   // resets to ones: an idle two-wire bus floats high
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         meta_r <= '1;
         o_q    <= '1;
      end
      else
      begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule

// ==== src/isf_top.sv ====
// status flags of a two-wire bus controller with axi4-lite access
//
// The register offsets and register access over AXI4-Lite were decided locally.
module isf_top
   import isf_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_srst,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   output logic [1:0]             o_bresp,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   input  wire logic              i_debug_read,
   input  wire logic              i_scl,
   input  wire logic              i_sda,
   input  wire logic              i_slave_tx_addr,
   input  wire logic              i_nack_driven,
   input  wire logic              i_tx_start,
   input  wire logic              i_tx_stop,
   input  wire logic              i_access_ready,
   input  wire logic              i_nack_rcvd,
   input  wire logic              i_arb_lost,
   input  wire logic              i_tx_shift_empty,
   input  wire logic              i_addressed_as_slave,
   input  wire logic              i_general_call,
   input  wire logic              i_tx_ready,
   output logic                   o_module_run,
   output logic                   o_loopback_enable,
   output logic                   o_irq
);
   // ****************************************
   // declarations
   // ****************************************
   logic              aw_hold_r;
   logic              w_hold_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              wr_go;
   logic              wr_hit;
   logic              rd_go;
   logic [31:0]       rd_mux;
   logic              rd_hit;
   logic [15:0]       w1c;
   logic [1:0]        mode_r;
   logic              run;
   logic              lb;
   logic [IRQ_N-1:0]  irq_en_r;
   logic [IRQ_N-1:0]  irq_st_r;
   logic [IRQ_N-1:0]  irq_ev;
   logic [1:0]        pins_s;
   logic              scl_s;
   logic              sda_s;
   logic              scl_d_r;
   logic              sda_d_r;
   logic              scl_rise;
   logic              start_det;
   logic              stop_det;
   logic              start_any;
   logic              stop_any;
   logic [3:0]        bit_cnt_r;
   logic [7:0]        rx_shift_r;
   logic [7:0]        rx_shift_nxt;
   logic [7:0]        rx_data_r;
   logic              rx_full_r;
   logic              byte_done;
   logic              rx_rd;
   logic              rx_free;
   logic              ovr_set;
   logic              rxb_set;
   logic              slave_tx_direction_r;
   logic              nack_sent_flag_r;
   logic              busy_r;
   logic              ovr_r;
   logic              rxr_r;
   logic              acr_r;
   logic              nack_r;
   logic              arb_r;
   logic              txe_r;
   logic              aas_r;
   logic              gc_r;
   logic              txr_r;
   logic [15:0]       status;

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   assign o_awready = !aw_hold_r && !o_bvalid;
   assign o_wready  = !w_hold_r && !o_bvalid;
   assign wr_go     = aw_hold_r && w_hold_r && !o_bvalid;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         aw_hold_r <= 1'b0;
         waddr_r   <= '0;
      end
      else if (i_awvalid && o_awready)
      begin
         aw_hold_r <= 1'b1;
         waddr_r   <= i_awaddr;
      end
      else if (wr_go)
         aw_hold_r <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         w_hold_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end
      else if (i_wvalid && o_wready)
      begin
         w_hold_r <= 1'b1;
         wdata_r  <= i_wdata;
         wstrb_r  <= i_wstrb;
      end
      else if (wr_go)
         w_hold_r <= 1'b0;
   end

   always_comb
   begin
      wr_hit = (waddr_r == OFS_STATUS) || (waddr_r == OFS_MODE) ||
               (waddr_r == OFS_IRQ_EN) || (waddr_r == OFS_IRQ_CLR);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_bvalid <= 1'b0;
         o_bresp  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         o_bvalid <= 1'b1;
         o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_bready)
         o_bvalid <= 1'b0;
   end

   // bit 15 is outside the mask, so writes to it vanish
   always_comb
   begin
      w1c = '0;
      if (wr_go && waddr_r == OFS_STATUS)
      begin
         w1c = wdata_r[15:0] & {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}}
               & ST_W1C_MASK;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         mode_r <= MODE_RST;
      else if (wr_go && waddr_r == OFS_MODE && wstrb_r[0])
         mode_r <= wdata_r[1:0];
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         irq_en_r <= '0;
      else if (wr_go && waddr_r == OFS_IRQ_EN && wstrb_r[0])
         irq_en_r <= wdata_r[IRQ_N-1:0];
   end

   assign run               = mode_r[MODE_RUN];
   assign lb                = mode_r[MODE_LB];
   assign o_module_run      = run;
   assign o_loopback_enable = lb;

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   assign o_arready = !o_rvalid;
   assign rd_go     = i_arvalid && o_arready;
   assign rx_rd     = rd_go && i_araddr == OFS_RXDATA && !i_debug_read;

   always_comb
   begin
      rd_mux = '0;
      rd_hit = 1'b1;
      case (i_araddr)
         OFS_STATUS:   rd_mux[15:0] = status;
         OFS_MODE:     rd_mux[1:0] = mode_r;
         OFS_RXDATA:   rd_mux[7:0] = rx_data_r;
         OFS_IRQ_EN:   rd_mux[IRQ_N-1:0] = irq_en_r;
         OFS_IRQ_CLR:  rd_mux = '0;
         OFS_IRQ_STAT: rd_mux[IRQ_N-1:0] = irq_st_r;
         default:      rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_rvalid <= 1'b0;
         o_rdata  <= '0;
         o_rresp  <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         o_rvalid <= 1'b1;
         o_rdata  <= rd_mux;
         o_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_rready)
         o_rvalid <= 1'b0;
   end

   // ****************************************
   // bus line sampling and conditions
   // ****************************************
   isf_sync #(.W(2)) u_sync
   (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_d    ({i_scl, i_sda}),
      .o_q    (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // sda may only move under a high clock for start and stop
   assign scl_rise  = scl_s && !scl_d_r;
   assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign start_any = run && (start_det || i_tx_start);
   assign stop_any  = run && (stop_det || i_tx_stop);

   // ****************************************
   // receive shift path
   // ****************************************
   assign rx_shift_nxt = {rx_shift_r[BYTE_BITS-2:0], sda_s};
   assign byte_done    = run && busy_r && scl_rise &&
                         bit_cnt_r == LAST_DATA_BIT;
   assign rx_free      = !rx_full_r || rx_rd;
   assign ovr_set      = byte_done && !rx_free;
   assign rxb_set      = byte_done && rx_free;

   always_ff @(posedge i_clk)
   begin
      if (i_srst || !run || start_any || stop_any)
         bit_cnt_r <= '0;
      else if (busy_r && scl_rise)
         bit_cnt_r <= (bit_cnt_r == ACK_BIT) ? 4'h0 : bit_cnt_r + 4'h1;
   end

   // keeps shifting even while an overrun is pending
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         rx_shift_r <= '0;
      else if (run && busy_r && scl_rise && bit_cnt_r != ACK_BIT)
         rx_shift_r <= rx_shift_nxt;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst || !run)
      begin
         rx_data_r <= '0;
         rx_full_r <= 1'b0;
      end
      else if (rxb_set)
      begin
         rx_data_r <= rx_shift_nxt;
         rx_full_r <= 1'b1;
      end
      else if (rx_rd && ovr_r)
         rx_data_r <= rx_shift_r;
      else if (rx_rd)
         rx_full_r <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst || !run)
         ovr_r <= 1'b0;
      else if (ovr_set)
         ovr_r <= 1'b1;
      else if (rx_rd)
         ovr_r <= 1'b0;
   end

   // ****************************************
   // status flags
   // ****************************************
   // loopback holds the direction flag down, even over a set
   always_ff @(posedge i_clk)
   begin
      if (i_srst || !run || lb)
         slave_tx_direction_r <= 1'b0;
      else if (i_slave_tx_addr)
         slave_tx_direction_r <= 1'b1;
      else if (start_any || stop_any || w1c[ST_SLAVE_TX_DIRECTION])
         slave_tx_direction_r <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst || !run)
         nack_sent_flag_r <= 1'b0;
      else if (i_nack_driven)
         nack_sent_flag_r <= 1'b1;
      else if (w1c[ST_NACK_SENT_FLAG])
         nack_sent_flag_r <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst || !run)
         busy_r <= 1'b0;
      else if (start_any)
         busy_r <= 1'b1;
      else if (stop_any || w1c[ST_BUSY])
         busy_r <= 1'b0;
   end

   // set wins over a write-one-clear in the same cycle
   always_ff @(posedge i_clk)
   begin
      if (i_srst || !run)
      begin
         rxr_r  <= 1'b0;
         acr_r  <= 1'b0;
         nack_r <= 1'b0;
         arb_r  <= 1'b0;
      end
      else
      begin
         rxr_r  <= rxb_set || (rxr_r && !w1c[ST_RXR] && !rx_rd);
         acr_r  <= i_access_ready || (acr_r && !w1c[ST_ACR]);
         nack_r <= i_nack_rcvd || (nack_r && !w1c[ST_NACK]);
         arb_r  <= i_arb_lost || (arb_r && !w1c[ST_ARB]);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         txe_r <= ST_RST[ST_TXE];
         aas_r <= ST_RST[ST_AAS];
         gc_r  <= ST_RST[ST_GC];
         txr_r <= ST_RST[ST_TXR];
      end
      else
      begin
         txe_r <= i_tx_shift_empty;
         aas_r <= i_addressed_as_slave;
         gc_r  <= i_general_call;
         txr_r <= i_tx_ready;
      end
   end

   assign status = {1'b0, slave_tx_direction_r, nack_sent_flag_r, busy_r, ovr_r, txe_r, aas_r,
                    gc_r, 3'h0, txr_r, rxr_r, acr_r, nack_r, arb_r};

   // ****************************************
   // interrupt status
   // ****************************************
   assign irq_ev = {stop_any, start_any, ovr_set, rxb_set};

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         irq_st_r <= '0;
      else if (wr_go && waddr_r == OFS_IRQ_CLR && wstrb_r[0])
         irq_st_r <= (irq_st_r & ~wdata_r[IRQ_N-1:0]) | irq_ev;
      else
         irq_st_r <= irq_st_r | irq_ev;
   end

   assign o_irq = |(irq_st_r & irq_en_r);

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   a_slave_tx_direction_set: assert property (
      run && !lb && i_slave_tx_addr |=> status[ST_SLAVE_TX_DIRECTION] [*2] or
      (status[ST_SLAVE_TX_DIRECTION] ##1 (start_any || stop_any || lb || !run ||
       w1c[ST_SLAVE_TX_DIRECTION])))
      else $error("direction flag not set on slave tx address");

   a_slave_tx_direction_loop: assert property (
      lb |=> !slave_tx_direction_r)
      else $error("direction flag set during loopback");

   a_nack_set: assert property (
      run && i_nack_driven |=> nack_sent_flag_r)
      else $error("nack sent flag missed");

   a_nack_run: assert property (
      !run |=> !nack_sent_flag_r && !busy_r && !ovr_r)
      else $error("flags survive module reset");

   a_busy_start: assert property (
      start_any ##1 (run && !stop_any && !w1c[ST_BUSY]) [*2] |=> busy_r)
      else $error("busy flag not held after start");

   a_busy_stop: assert property (
      busy_r && stop_any && !start_any |=> !busy_r)
      else $error("busy flag not cleared by stop");

   a_w1c_zero: assert property (
      wr_go && waddr_r == OFS_STATUS && !wdata_r[ST_BUSY] && run &&
      !stop_any |=> busy_r == $past(busy_r) || $past(start_any))
      else $error("writing zero changed busy flag");

   a_ovr_set: assert property (
      byte_done && rx_full_r && !rx_rd |=> ovr_r && status[ST_OVR])
      else $error("overrun not flagged");

   a_ovr_hold: assert property (
      ovr_r && run && !rx_rd |=> $stable(rx_data_r))
      else $error("data register overwritten during overrun");

   a_rsvd_zero: assert property (
      rd_go && i_araddr == OFS_STATUS |=> o_rdata[31:15] == '0)
      else $error("reserved status bit read nonzero");

   a_reset_val: assert property (
      $past(i_srst) |-> status == ST_RST)
      else $error("status wrong after reset");

   a_ovr_debug: assert property (
      ovr_r && rd_go && i_araddr == OFS_RXDATA && i_debug_read && run
      |=> ovr_r)
      else $error("debug read cleared overrun");

   a_irq_sticky: assert property (
      irq_ev[IRQ_RXB] |=> irq_st_r[IRQ_RXB] &&
      (o_irq || !irq_en_r[IRQ_RXB]))
      else $error("byte interrupt not held or not raised");
endmodule

// ==== sim/isf_bus_model.sv ====
// remote master that drives the two-wire bus pins
module isf_bus_model
(
   output logic o_scl,
   output logic o_sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // link timing, one bit every 400 ns
   // ****************************************
   localparam int HALF = 200;
   localparam int QTR  = 100;
   // pull-ups hold both lines high, clock stands still between frames
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // odd offset keeps the link out of phase with the block clock
   task automatic start_c();
      #7;
      o_sda = 1'b0;
      #HALF;
      o_scl = 1'b0;
      #QTR;
   endtask
   task automatic bit_tx(input logic b);
      o_sda = b;
      #QTR;
      o_scl = 1'b1;
      #HALF;
      o_scl = 1'b0;
      #QTR;
   endtask
   // msb first, then the ack slot with the line released
   task automatic byte_tx(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         bit_tx(d[i]);
      bit_tx(1'b1);
   endtask
   task automatic stop_c();
      o_sda = 1'b0;
      #QTR;
      o_scl = 1'b1;
      #QTR;
      o_sda = 1'b1;
      #HALF;
   endtask
endmodule

// ==== sim/isf_top_tb.sv ====
// self-checking bench for the status flag block
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module isf_top_tb
   import isf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // signals
   // ****************************************
   logic        i_clk, i_srst, awv, wv, bready, arv, rready, dbg;
   logic        tse, addressed_as_slave_flag, gc, txr, awready, wready, bvalid, arready;
   logic        rvalid, run, lb, irq;
   logic [7:0]  awaddr, araddr, a, b, c;
   logic [31:0] wdata, rdata, d, w;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [6:0]  ev, m;
   wire         scl, sda;
   int          n_mismatch, cmp_count;
   initial
   begin
      {i_clk, awv, wv, bready, arv, rready, dbg, addressed_as_slave_flag, gc} = '0;
      {awaddr, araddr, wdata, ev, n_mismatch, cmp_count} = '0;
      {i_srst, tse, txr} = 3'h7;
      wstrb = 4'hF;
   end
   always #25 i_clk = ~i_clk;
   isf_bus_model bus (.o_scl(scl), .o_sda(sda));
   isf_top DUT (
      .i_clk(i_clk), .i_srst(i_srst), .i_awvalid(awv), .o_awready(awready),
      .i_awaddr(awaddr), .i_wvalid(wv), .o_wready(wready), .i_wdata(wdata),
      .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arv), .o_arready(arready), .i_araddr(araddr),
      .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
      .i_debug_read(dbg), .i_scl(scl), .i_sda(sda), .i_slave_tx_addr(ev[0]),
      .i_nack_driven(ev[1]), .i_tx_start(ev[2]), .i_tx_stop(ev[3]),
      .i_access_ready(ev[4]), .i_nack_rcvd(ev[5]), .i_arb_lost(ev[6]),
      .i_tx_shift_empty(tse), .i_addressed_as_slave(addressed_as_slave_flag),
      .i_general_call(gc), .i_tx_ready(txr), .o_module_run(run),
      .o_loopback_enable(lb), .o_irq(irq));
   // ****************************************
   // expectations
   // ****************************************
   function automatic logic [15:0] fl(input logic [6:0] k);
      fl = {1'b0, k[0], k[1], k[2], 9'h000, k[4], k[5], k[6]};
   endfunction
   function automatic logic [15:0] lv();
      lv = {5'h00, tse, addressed_as_slave_flag, gc, 3'h0, txr, 4'h0};
   endfunction
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt,
                     output logic [1:0] rs);
      bit done;
      @(posedge i_clk);
      awv <= 1'b1;
      awaddr <= ad;
      wv <= 1'b1;
      wdata <= dt;
      bready <= 1'b1;
      done = 0;
      while (!done)
      begin
         @(posedge i_clk);
         if (awv && awready) awv <= 1'b0;
         if (wv && wready) wv <= 1'b0;
         if (bvalid === 1'b1)
         begin
            rs = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] ad, output logic [31:0] dt,
                     output logic [1:0] rs);
      bit done;
      @(posedge i_clk);
      arv <= 1'b1;
      araddr <= ad;
      rready <= 1'b1;
      done = 0;
      while (!done)
      begin
         @(posedge i_clk);
         if (arv && arready) arv <= 1'b0;
         if (rvalid === 1'b1)
         begin
            dt = rdata;
            rs = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic wrk(input logic [7:0] ad, input logic [31:0] dt);
      logic [1:0] rs;
      wr(ad, dt, rs);
   endtask
   task automatic st_is(input logic [15:0] e);
      logic [31:0] dt;
      logic [1:0]  rs;
      rd(OFS_STATUS, dt, rs);
      `CHK(dt, {16'h0000, e})
   endtask
   task automatic pulse(input logic [6:0] k);
      @(posedge i_clk);
      ev <= k;
      @(posedge i_clk);
      ev <= 7'h00;
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ****************************************
   // watchdog, far above the expected run
   // ****************************************
   initial
   begin
      #2000000;
      n_mismatch++;
      print_verdict();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      void'($urandom(21));
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      st_is(ST_RST);
      rd(OFS_MODE, d, r);
      `CHK(d, 32'h00000000)
      wrk(OFS_MODE, 32'h00000001);
      // random flag sets and w1c writes, first two writes are corners
      for (int i = 0; i < 16; i++)
      begin
         wrk(OFS_STATUS, 32'h0000FFFF);
         m = 7'($urandom) & 7'h77;
         {tse, addressed_as_slave_flag, gc, txr} <= 4'($urandom);
         pulse(m);
         st_is(fl(m) | lv());
         w = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF : $urandom;
         wrk(OFS_STATUS, w);
         st_is((fl(m) & ~w[15:0]) | lv());
      end
      // last random write may leave flags that stop does not touch
      wrk(OFS_STATUS, 32'h0000FFFF);
      {tse, addressed_as_slave_flag, gc, txr} <= 4'h9;
      pulse(7'h01);
      pulse(7'h08);
      st_is(lv());
      pulse(7'h05);
      wrk(OFS_MODE, 32'h00000003);
      `CHK(lb, 1'b1)
      st_is(16'h1000 | lv());
      wrk(OFS_MODE, 32'h00000001);
      pulse(7'h07);
      wrk(OFS_MODE, 32'h00000000);
      `CHK(run, 1'b0)
      st_is(lv());
      wrk(OFS_MODE, 32'h00000001);
      wrk(OFS_IRQ_CLR, 32'h0000000F);
      // bus frame: start clears direction, bytes overrun the reader
      pulse(7'h01);
      bus.start_c();
      st_is(16'h1000 | lv());
      wrk(OFS_IRQ_EN, 32'h00000001);
      {a, b, c} = 24'($urandom);
      bus.byte_tx(a);
      st_is(16'h1008 | lv());
      `CHK(irq, 1'b1)
      rd(OFS_IRQ_STAT, d, r);
      `CHK(d, 32'h00000005)
      wrk(OFS_IRQ_EN, 32'h00000000);
      `CHK(irq, 1'b0)
      bus.byte_tx(b);
      bus.byte_tx(c);
      st_is(16'h1808 | lv());
      @(posedge i_clk);
      dbg <= 1'b1;
      rd(OFS_RXDATA, d, r);
      dbg <= 1'b0;
      `CHK(d, {24'h0, a})
      st_is(16'h1808 | lv());
      rd(OFS_RXDATA, d, r);
      `CHK(d, {24'h0, a})
      // cpu read during overrun loads the newer byte, ready bit drops
      st_is(16'h1000 | lv());
      rd(OFS_RXDATA, d, r);
      `CHK(d, {24'h0, c})
      bus.stop_c();
      st_is(lv());
      wrk(OFS_IRQ_EN, 32'h00000001);
      `CHK(irq, 1'b1)
      wrk(OFS_IRQ_CLR, 32'h0000000F);
      `CHK(irq, 1'b0)
      rd(OFS_IRQ_STAT, d, r);
      `CHK(d, 32'h00000000)
      // unmapped place
      rd(8'h18, d, r);
      `CHK(r, RESP_SLVERR)
      `CHK(d, 32'h00000000)
      wr(8'h18, 32'hFFFFFFFF, r);
      `CHK(r, RESP_SLVERR)
      print_verdict();
   end
endmodule
